// ===== hdl/dopc_consts.vh
// Register map constants for the offset and power configuration slice
`ifndef DOPC_CONSTS_VH
`define DOPC_CONSTS_VH
`define DOPC_ADDR_OFS_A_LO     5'h14
`define DOPC_ADDR_OFS_B_LO     5'h15
`define DOPC_ADDR_OFS_A_UP     5'h16
`define DOPC_ADDR_OFS_B_UP     5'h17
`define DOPC_ADDR_PWR          5'h18
`define DOPC_ADDR_REF          5'h19
`define DOPC_ADDR_FAC_A        5'h1a
`define DOPC_ADDR_FAC_B        5'h1b
`define DOPC_ADDR_FAC_C        5'h1c
`define DOPC_RST_ZERO          8'h00
`define DOPC_RST_PWR           8'h83
`define DOPC_BIT_FOUR_WIRE     2
`define DOPC_BIT_CLKP_SLEEP_A  1
`define DOPC_BIT_CLKP_SLEEP_B  0
`define DOPC_BIT_TSENSE        7
`define DOPC_BIT_RECV_SLEEP    6
`define DOPC_BIT_SLEEP_B       3
`define DOPC_BIT_SLEEP_A       2
`define DOPC_BIT_EXTREF        2
`define DOPC_OFS_UP_MSB        7
`define DOPC_OFS_UP_LSB        3
`endif

// ===== hdl/dopc_regs.v
// Offset, serial mode and power configuration register slice
//
// Behaviour
// [RL1] Channel A upper offset in 0x16[7:3]
// [RL2] Channel B upper offset in 0x17[7:3]
// [RL3] Bit 0x17[2] selects four-pin serial
// [RL4] Four-pin mode: readback pin output only
// [RL5] Bit 0x17[1] sleeps channel A clockpath
// [RL6] Bit 0x17[0] sleeps channel B clockpath
// [RL7] Host keeps clock running unless powering down
// [RL8] Bit 0x18[7] powers temperature sensor
// [RL9] Bit 0x18[6] sleeps clock/strobe receivers
// [RL10] Bit 0x18[3] sleeps channel B converter
// [RL11] Bit 0x18[2] sleeps channel A converter
// [RL12] Register 0x18 resets to 0x83
// [RL13] Bit 0x19[2] selects external reference
// [RL14] Registers 0x1A, 0x1B factory storage
// [RL15] Thirteen-bit offsets from low and upper
// [RL16] Channel A low write loads all offsets
// [RL17] Host writes channel A low last
// [RL18] Reads return last written value
`timescale 1ns/1ps
`include "dopc_consts.vh"
module dopc_regs
#(
   parameter ADDR_W = 5,
   parameter OFS_W  = 13
)
(
   ref_clk,
   resetn,
   wr_en,
   rd_en,
   addr,
   wdata,
   rdata,
   rd_hit,
   offset_a,
   offset_b,
   four_wire_select,
   readback_dedicated,
   clkpath_sleep_a,
   clkpath_sleep_b,
   tsense_enable,
   recv_sleep,
   conv_sleep_a,
   conv_sleep_b,
   extref_select
);
   input  wire              ref_clk;
   input  wire              resetn;
   input  wire              wr_en;
   input  wire              rd_en;
   input  wire [ADDR_W-1:0] addr;
   input  wire [7:0]        wdata;
   output reg  [7:0]        rdata;
   output reg               rd_hit;
   output reg  [OFS_W-1:0]  offset_a;
   output reg  [OFS_W-1:0]  offset_b;
   output reg               four_wire_select;
   output reg               readback_dedicated;
   output reg               clkpath_sleep_a;
   output reg               clkpath_sleep_b;
   output reg               tsense_enable;
   output reg               recv_sleep;
   output reg               conv_sleep_a;
   output reg               conv_sleep_b;
   output reg               extref_select;

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   reg  [7:0] ofs_a_lo_ff;
   reg  [7:0] ofs_b_lo_ff;
   reg  [7:0] ofs_a_up_ff;
   reg  [7:0] ofs_b_up_ff;
   reg  [7:0] pwr_ff;
   reg  [7:0] ref_ff;
   reg  [7:0] fac_a_ff;
   reg  [7:0] fac_b_ff;
   reg  [7:0] fac_c_ff;
   reg  [7:0] nxt_rdata;
   reg        nxt_hit;

   // Address match
   function hit;
      input [ADDR_W-1:0] a;
      input [ADDR_W-1:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         ofs_a_lo_ff <= `DOPC_RST_ZERO;
         ofs_b_lo_ff <= `DOPC_RST_ZERO;
         // [RL1] Upper A zero
         ofs_a_up_ff <= `DOPC_RST_ZERO;
         // [RL2] Upper B zero
         ofs_b_up_ff <= `DOPC_RST_ZERO;
         // [RL12] Power reset value
         pwr_ff      <= `DOPC_RST_PWR;
         ref_ff      <= `DOPC_RST_ZERO;
         // [RL14] Factory storage reset
         fac_a_ff    <= `DOPC_RST_ZERO;
         fac_b_ff    <= `DOPC_RST_ZERO;
         fac_c_ff    <= `DOPC_RST_ZERO;
      end
      else if (wr_en)
      begin
         // [RL18] Full byte stored
         if (hit(addr, `DOPC_ADDR_OFS_A_LO))
            ofs_a_lo_ff <= wdata;
         else if (hit(addr, `DOPC_ADDR_OFS_B_LO))
            ofs_b_lo_ff <= wdata;
         else if (hit(addr, `DOPC_ADDR_OFS_A_UP))
            ofs_a_up_ff <= wdata;
         else if (hit(addr, `DOPC_ADDR_OFS_B_UP))
            ofs_b_up_ff <= wdata;
         else if (hit(addr, `DOPC_ADDR_PWR))
            pwr_ff <= wdata;
         else if (hit(addr, `DOPC_ADDR_REF))
            ref_ff <= wdata;
         else if (hit(addr, `DOPC_ADDR_FAC_A))
            fac_a_ff <= wdata;
         else if (hit(addr, `DOPC_ADDR_FAC_B))
            fac_b_ff <= wdata;
         else if (hit(addr, `DOPC_ADDR_FAC_C))
            fac_c_ff <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Readback
   always @*
   begin
      nxt_rdata = `DOPC_RST_ZERO;
      nxt_hit   = 1'b1;
      if (hit(addr, `DOPC_ADDR_OFS_A_LO))
         nxt_rdata = ofs_a_lo_ff;
      else if (hit(addr, `DOPC_ADDR_OFS_B_LO))
         nxt_rdata = ofs_b_lo_ff;
      else if (hit(addr, `DOPC_ADDR_OFS_A_UP))
         nxt_rdata = ofs_a_up_ff;
      else if (hit(addr, `DOPC_ADDR_OFS_B_UP))
         nxt_rdata = ofs_b_up_ff;
      else if (hit(addr, `DOPC_ADDR_PWR))
         nxt_rdata = pwr_ff;
      else if (hit(addr, `DOPC_ADDR_REF))
         nxt_rdata = ref_ff;
      else if (hit(addr, `DOPC_ADDR_FAC_A))
         nxt_rdata = fac_a_ff;
      else if (hit(addr, `DOPC_ADDR_FAC_B))
         nxt_rdata = fac_b_ff;
      else if (hit(addr, `DOPC_ADDR_FAC_C))
         nxt_rdata = fac_c_ff;
      else
         nxt_hit = 1'b0;
   end

   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         rdata  <= 8'h00;
         rd_hit <= 1'b0;
      end
      else if (rd_en)
      begin
         // [RL18] Return stored byte
         rdata  <= nxt_rdata;
         rd_hit <= nxt_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Offset block load
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         offset_a <= {OFS_W{1'b0}};
         offset_b <= {OFS_W{1'b0}};
      end
      // [RL16] Autosync on A low
      else if (wr_en && hit(addr, `DOPC_ADDR_OFS_A_LO))
      begin
         // [RL15] Join upper and low
         offset_a <= {ofs_a_up_ff[`DOPC_OFS_UP_MSB:`DOPC_OFS_UP_LSB], wdata};
         offset_b <= {ofs_b_up_ff[`DOPC_OFS_UP_MSB:`DOPC_OFS_UP_LSB], ofs_b_lo_ff};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control outputs
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         four_wire_select   <= 1'b0;
         readback_dedicated <= 1'b0;
         clkpath_sleep_a    <= 1'b0;
         clkpath_sleep_b    <= 1'b0;
         tsense_enable      <= 1'b1;
         recv_sleep         <= 1'b0;
         conv_sleep_a       <= 1'b0;
         conv_sleep_b       <= 1'b0;
         extref_select      <= 1'b0;
      end
      else
      begin
         // [RL3] Serial pin mode
         four_wire_select   <= ofs_b_up_ff[`DOPC_BIT_FOUR_WIRE];
         // [RL4] Readback pin dedicated
         readback_dedicated <= ofs_b_up_ff[`DOPC_BIT_FOUR_WIRE];
         // [RL5] Clock path A sleep
         clkpath_sleep_a    <= ofs_b_up_ff[`DOPC_BIT_CLKP_SLEEP_A];
         // [RL6] Clock path B sleep
         clkpath_sleep_b    <= ofs_b_up_ff[`DOPC_BIT_CLKP_SLEEP_B];
         // [RL8] Temperature sensor power
         tsense_enable      <= pwr_ff[`DOPC_BIT_TSENSE];
         // [RL9] Receiver sleep
         recv_sleep         <= pwr_ff[`DOPC_BIT_RECV_SLEEP];
         // [RL11] Converter A sleep
         conv_sleep_a       <= pwr_ff[`DOPC_BIT_SLEEP_A];
         // [RL10] Converter B sleep
         conv_sleep_b       <= pwr_ff[`DOPC_BIT_SLEEP_B];
         // [RL13] Reference source
         extref_select      <= ref_ff[`DOPC_BIT_EXTREF];
      end
   end
endmodule

// ===== sim/dopc_host.sv
// Host model driving the register port
`timescale 1ns/1ps
module dopc_host (
   input  wire       ref_clk,
   input  wire [7:0] rdata,
   input  wire       rd_hit,
   output reg        wr_en,
   output reg        rd_en,
   output reg  [4:0] addr,
   output reg  [7:0] wdata
);
   initial {wr_en, rd_en, addr, wdata} = 15'h0000;
   task wr(input [4:0] a, input [7:0] d);
   begin
      @(negedge ref_clk);
      {wr_en, addr, wdata} = {1'b1, a, d};
      @(negedge ref_clk);
      {wr_en, addr, wdata} = {1'b0, ~a, ~d};
   end
   endtask
   task rd(input [4:0] a, output [7:0] d, output h);
   begin
      @(negedge ref_clk);
      {rd_en, addr} = {1'b1, a};
      @(negedge ref_clk);
      {rd_en, addr} = {1'b0, ~a};
      d = rdata;
      h = rd_hit;
   end
   endtask
endmodule

// ===== sim/dopc_regs_properties.sv
// Checker for the offset and power register slice
`timescale 1ns/1ps
module dopc_regs_chk (
   input wire        ref_clk, resetn, wr_en, rd_en,
   input wire [4:0]  addr,
   input wire [7:0]  wdata, rdata,
   input wire        rd_hit, four_wire_select, readback_dedicated,
   input wire [12:0] offset_a, offset_b,
   input wire        clkpath_sleep_a, clkpath_sleep_b, tsense_enable,
   input wire        recv_sleep, conv_sleep_a, conv_sleep_b, extref_select
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   reg  [7:0] wd1_ff, wd2_ff;
   wire w14 = wr_en && addr == 5'h14;
   wire w17 = wr_en && addr == 5'h17;
   wire w18 = wr_en && addr == 5'h18;
   wire w19 = wr_en && addr == 5'h19;
   always @(posedge ref_clk) begin
      wd1_ff <= wdata;
      wd2_ff <= wd1_ff;
   end
   ////////////////////////////////////////
   fw_mode_a: assert property (w17 ##1 !w17 |=>
      {four_wire_select, clkpath_sleep_a, clkpath_sleep_b} == wd2_ff[2:0]) else $error("bad mode");
   pin_dedic_a: assert property (readback_dedicated == four_wire_select)
      else $error("bad pin use");
   pwr_bits_a: assert property (w18 ##1 !w18 |=>
      {tsense_enable, recv_sleep, conv_sleep_b, conv_sleep_a} == {wd2_ff[7:6], wd2_ff[3:2]})
      else $error("bad power bits");
   ref_sel_a: assert property (w19 ##1 !w19 |=> extref_select == wd2_ff[2])
      else $error("bad reference");
   rst_state_a: assert property ($rose(resetn) |-> tsense_enable && !recv_sleep)
      else $error("bad reset state");
   ofs_load_a: assert property (w14 |=> offset_a[7:0] == $past(wdata))
      else $error("bad offset load");
   ofs_hold_a: assert property (!w14 |=> $stable(offset_a) && $stable(offset_b))
      else $error("offset moved");
   rd_miss_a: assert property (rd_en && (addr < 5'h14 || addr > 5'h1c) |=>
      !rd_hit && rdata == 8'h00) else $error("bad unmapped read");
   rd_hold_a: assert property (!rd_en |=> $stable(rdata) && $stable(rd_hit))
      else $error("read data moved");
   cover property (w14);
   cover property (rd_hit);
   cover property (four_wire_select);
endmodule
bind dopc_regs dopc_regs_chk u_chk (.*);

// ===== sim/dopc_regs_test.sv
// Self-checking bench for the register slice
`timescale 1ns/1ps
module dopc_regs_test;
   reg         ref_clk, resetn, h;
   reg  [7:0]  d;
   reg  [4:0]  a;
   wire        wr_en, rd_en, rd_hit, four_wire_select, readback_dedicated;
   wire        clkpath_sleep_a, clkpath_sleep_b, tsense_enable, recv_sleep;
   wire        conv_sleep_a, conv_sleep_b, extref_select;
   wire [4:0]  addr;
   wire [7:0]  wdata, rdata;
   wire [12:0] offset_a, offset_b;
   integer     n_errors, n_compared, cyc;
   dopc_regs dut (.*);
   dopc_host u_host (.*);
   initial begin
      ref_clk = 0;
      forever #4 ref_clk = ~ref_clk;
   end
   task chk(input [12:0] g, input [12:0] e);
   begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
         n_errors = n_errors + 1;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   end
   endtask
   task rdc(input [4:0] ra, input [7:0] e, input eh);
   begin
      u_host.rd(ra, d, h);
      chk(d, e);
      chk(h, eh);
   end
   endtask
   ////////////////////////////////////////
   task t_reset;
      for (a = 5'h14; a <= 5'h1c; a = a + 1)
         rdc(a, a == 5'h18 ? 8'h83 : 8'h00, 1);
   endtask
   task t_ofs;
   begin
      u_host.wr(5'h16, 8'ha8);
      u_host.wr(5'h17, 8'h50);
      u_host.wr(5'h15, 8'h77);
      chk(offset_a | offset_b, 0);
      u_host.wr(5'h14, 8'h3c);
      chk(offset_a, 13'h153c);
      chk(offset_b, 13'h0a77);
   end
   endtask
   task t_ctl;
   begin
      u_host.wr(5'h17, 8'h07);
      @(negedge ref_clk);
      chk({four_wire_select, readback_dedicated, clkpath_sleep_a, clkpath_sleep_b}, 4'hf);
      u_host.wr(5'h18, 8'h4c);
      @(negedge ref_clk);
      chk({tsense_enable, recv_sleep, conv_sleep_b, conv_sleep_a}, 4'h7);
      u_host.wr(5'h19, 8'h04);
      @(negedge ref_clk);
      chk(extref_select, 1);
   end
   endtask
   task t_rw;
   begin
      for (a = 5'h14; a <= 5'h1c; a = a + 1)
      begin
         u_host.wr(a, 8'ha5 ^ {3'h0, a});
         rdc(a, 8'ha5 ^ {3'h0, a}, 1);
      end
      u_host.wr(5'h1d, 8'hff);
      rdc(5'h1d, 8'h00, 0);
      rdc(5'h13, 8'h00, 0);
   end
   endtask
   task complete_run;
   begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   always @(posedge ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 2000)
      begin
         n_errors = n_errors + 1;
         complete_run;
      end
   end
   initial begin
      {n_errors, n_compared, cyc, resetn} = 0;
      repeat (3) @(negedge ref_clk);
      resetn = 1;
      t_reset;
      t_ofs;
      t_ctl;
      t_rw;
      complete_run;
   end
endmodule
